// *** include/icc_defines.svh ***
`ifndef ICC_DEFINES_SVH
`define ICC_DEFINES_SVH
`define ICC_ADDR_CONTROL    4'h0
`define ICC_ADDR_STATUS     4'h4
`define ICC_ADDR_MASK       4'h8
`define ICC_ADDR_COUNT      4'hc
`define ICC_BIT_ENABLE      15
`define ICC_BIT_IDLE_HALT   13
`define ICC_BIT_FIRST_EDGE  9
`define ICC_BIT_WIDE        8
`define ICC_BIT_TIMEBASE    7
`define ICC_BIT_EPI_HI      6
`define ICC_BIT_EPI_LO      5
`define ICC_BIT_OVERFLOW    4
`define ICC_BIT_NOT_EMPTY   3
`define ICC_BIT_MODE_HI     2
`define ICC_CTRL_WMASK      32'h0000a3e7
`define ICC_CTRL_RESET      32'h00000000
`define ICC_MODE_EDGE_FIRST 3'h6
`define ICC_STAT_CAPTURE    0
`define ICC_STAT_IRQ_GROUP  1
`define ICC_STAT_OVERFLOW   2
`define ICC_STAT_WIDTH      3
`define ICC_BUF_DEPTH       4
`endif

// *** include/icc_pkg.sv ***
package icc_pkg;
   typedef enum logic [2:0] {
      ICC_IDLE  = 3'b001,
      ICC_WRESP = 3'b010,
      ICC_RDATA = 3'b100
   } icc_bus_state_t;
endpackage : icc_pkg

// *** hdl/icc_event_counter.sv ***
`timescale 1ns/1ps
`include "icc_defines.svh"
module icc_event_counter (
   input  wire logic       clock_i,
   input  wire logic       reset_i,
   input  wire logic       clear_i,
   input  wire logic       event_i,
   input  wire logic [1:0] per_irq_i,
   output logic            group_done_o
);
   logic [1:0] count_r;
   logic [1:0] count_nxt;
   logic       done_nxt;
   logic       done_r;

   always_comb begin
      count_nxt = count_r;
      done_nxt  = 1'b0;
      if (clear_i) begin
         count_nxt = 2'h0;
      end else if (event_i) begin
         // Greater-or-equal keeps a mid-group field change from skipping a wrap
         if (count_r >= per_irq_i) begin
            count_nxt = 2'h0;
            done_nxt  = 1'b1;
         end else begin
            count_nxt = count_r + 2'h1;
         end
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         count_r <= 2'h0;
         done_r  <= 1'b0;
      end else begin
         count_r <= count_nxt;
         done_r  <= done_nxt;
      end
   end

   assign group_done_o = done_r;
endmodule : icc_event_counter

// *** hdl/icc_top.sv ***
`timescale 1ns/1ps
`include "icc_defines.svh"
// Operation
// - Enable runs unit; clearing resets buffer, counters and overflow flag, stops work, blocks interrupts.
// - Idle-halt set stops unit while system idle; clear keeps running.
// - In mode 110, first-edge bit picks rising (1) or falling (0) first.
// - Wide bit set captures 32-bit timer value, else 16-bit.
// - Timebase bit picks second timer (1) or third (0); ignored when wide.
// - Interrupt after every 1st, 2nd, 3rd or 4th capture per field code.
// - Overflow flag is read-only, reads one after overflow occurred.
// - Not-empty flag reads one while a captured value remains.
// - Unimplemented control bits always read zero.
module icc_top
   import icc_pkg::*;
#(
   parameter int DEPTH = `ICC_BUF_DEPTH
) (
   input  wire logic        clock_i,
   input  wire logic        reset_i,
   input  wire logic        system_idle_i,
   input  wire logic        capture_pin_i,
   input  wire logic [31:0] second_timer_i,
   input  wire logic [15:0] third_timer_i,
   input  wire logic        buf_pop_i,
   output logic [31:0]      buf_data_o,
   output logic             irq_o,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ---------------------------------------------------------------
   // Pin synchroniser and edge detect
   // ---------------------------------------------------------------
   logic sync1_r, sync2_r, last_r;
   logic sync1_nxt, sync2_nxt, last_nxt;
   logic enable, active, rise, fall;
   logic [31:0] control_r, control_nxt;

   assign enable = control_r[`ICC_BIT_ENABLE];
   assign active = enable & ~(control_r[`ICC_BIT_IDLE_HALT] & system_idle_i);

   always_comb begin
      sync1_nxt = capture_pin_i;
      sync2_nxt = sync1_r;
      // Tracks the pin even while halted or off, so no stale edge fires on resume
      last_nxt  = sync2_r;
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         last_r  <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         last_r  <= last_nxt;
      end
   end

   assign rise = active & sync2_r & ~last_r;
   assign fall = active & ~sync2_r & last_r;

   // ---------------------------------------------------------------
   // Capture event selection
   // ---------------------------------------------------------------
   // Mode field codes other than 110 are handled as every edge here; the full
   // mode decoder sits outside this block.
   logic first_done_r, first_done_nxt;
   logic capture_ev;

   always_comb begin
      first_done_nxt = first_done_r;
      capture_ev     = rise | fall;
      if (control_r[`ICC_BIT_MODE_HI:0] == `ICC_MODE_EDGE_FIRST && !first_done_r) begin
         capture_ev     = control_r[`ICC_BIT_FIRST_EDGE] ? rise : fall;
         first_done_nxt = capture_ev;
      end
      if (!enable) begin
         first_done_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         first_done_r <= 1'b0;
      end else begin
         first_done_r <= first_done_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Timestamp and capture buffer
   // ---------------------------------------------------------------
   logic [31:0] stamp;
   logic [31:0] mem_r   [DEPTH];
   logic [31:0] mem_nxt [DEPTH];
   logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [AW:0]   cnt_r, cnt_nxt;
   logic          full, not_empty, push, pop, ovf_ev;
   logic          ovf_r, ovf_nxt;

   always_comb begin
      if (control_r[`ICC_BIT_WIDE]) begin
         stamp = second_timer_i;
      end else if (control_r[`ICC_BIT_TIMEBASE]) begin
         stamp = {16'h0000, second_timer_i[15:0]};
      end else begin
         stamp = {16'h0000, third_timer_i};
      end
   end

   assign full      = (cnt_r == (AW+1)'(DEPTH));
   assign not_empty = (cnt_r != '0);
   assign pop       = buf_pop_i & not_empty;
   assign push      = capture_ev & ~full;
   assign ovf_ev    = capture_ev & full;

   generate
      for (genvar g = 0; g < DEPTH; g++) begin : g_mem
         always_comb begin
            mem_nxt[g] = mem_r[g];
            if (push && wp_r == AW'(g)) begin
               mem_nxt[g] = stamp;
            end
         end
         always_ff @(posedge clock_i or posedge reset_i) begin
            if (reset_i) begin
               mem_r[g] <= 32'h00000000;
            end else begin
               mem_r[g] <= mem_nxt[g];
            end
         end
      end
   endgenerate

   always_comb begin
      wp_nxt  = wp_r;
      rp_nxt  = rp_r;
      cnt_nxt = cnt_r;
      ovf_nxt = ovf_r | ovf_ev;
      if (push) begin
         wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
         rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      if (!enable) begin
         wp_nxt  = '0;
         rp_nxt  = '0;
         cnt_nxt = '0;
         ovf_nxt = 1'b0;
      end
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         ovf_r <= 1'b0;
      end else begin
         wp_r  <= wp_nxt;
         rp_r  <= rp_nxt;
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
      end
   end

   assign buf_data_o = not_empty ? mem_r[rp_r] : 32'h00000000;

   // ---------------------------------------------------------------
   // Event grouping
   // ---------------------------------------------------------------
   logic group_done;

   icc_event_counter u_count (
      .clock_i      (clock_i),
      .reset_i      (reset_i),
      .clear_i      (~enable),
      .event_i      (push),
      .per_irq_i    (control_r[`ICC_BIT_EPI_HI:`ICC_BIT_EPI_LO]),
      .group_done_o (group_done)
   );

   // ---------------------------------------------------------------
   // AXI4-Lite slave
   // ---------------------------------------------------------------
   icc_bus_state_t st_r, st_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [3:0]  awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0]  wstrb_r, wstrb_nxt;
   logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
   logic [`ICC_STAT_WIDTH-1:0] status_r, status_nxt, mask_r, mask_nxt;
   logic [`ICC_STAT_WIDTH-1:0] set_ev;
   logic [31:0] wmask, ctrl_rd;
   logic        do_write;

   assign s_axi_awready = (st_r == ICC_IDLE) & ~aw_have_r;
   assign s_axi_wready  = (st_r == ICC_IDLE) & ~w_have_r;
   assign s_axi_arready = (st_r == ICC_IDLE) & ~aw_have_r & ~w_have_r;
   assign s_axi_bvalid  = (st_r == ICC_WRESP);
   assign s_axi_rvalid  = (st_r == ICC_RDATA);
   assign s_axi_bresp   = bresp_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;

   assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
   assign do_write = (st_r == ICC_IDLE) & aw_have_r & w_have_r;
   assign set_ev = {ovf_ev, group_done, push} & {`ICC_STAT_WIDTH{enable}};

   always_comb begin
      ctrl_rd = control_r & `ICC_CTRL_WMASK;
      ctrl_rd[`ICC_BIT_OVERFLOW]  = ovf_r;
      ctrl_rd[`ICC_BIT_NOT_EMPTY] = not_empty;
   end

   always_comb begin
      st_nxt      = st_r;
      rdata_nxt   = rdata_r;
      bresp_nxt   = bresp_r;
      rresp_nxt   = rresp_r;
      awaddr_nxt  = awaddr_r;
      wdata_nxt   = wdata_r;
      wstrb_nxt   = wstrb_r;
      aw_have_nxt = aw_have_r;
      w_have_nxt  = w_have_r;
      control_nxt = control_r;
      mask_nxt    = mask_r;
      status_nxt  = status_r;
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_nxt  = s_axi_awaddr;
         aw_have_nxt = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_nxt  = s_axi_wdata;
         wstrb_nxt  = s_axi_wstrb;
         w_have_nxt = 1'b1;
      end
      case (st_r)
         ICC_IDLE: begin
            if (do_write) begin
               aw_have_nxt = 1'b0;
               w_have_nxt  = 1'b0;
               bresp_nxt   = 2'h0;
               st_nxt      = ICC_WRESP;
               case ({awaddr_r[3:2], 2'h0})
                  `ICC_ADDR_CONTROL: begin
                     // Status bits are never stored, so writes to them vanish
                     control_nxt = (control_r & ~(wmask & `ICC_CTRL_WMASK)) |
                                   (wdata_r & wmask & `ICC_CTRL_WMASK);
                  end
                  `ICC_ADDR_STATUS: begin
                     status_nxt = status_r & ~(wdata_r[`ICC_STAT_WIDTH-1:0] & wmask[`ICC_STAT_WIDTH-1:0]);
                  end
                  `ICC_ADDR_MASK: begin
                     mask_nxt = (mask_r & ~wmask[`ICC_STAT_WIDTH-1:0]) |
                                (wdata_r[`ICC_STAT_WIDTH-1:0] & wmask[`ICC_STAT_WIDTH-1:0]);
                  end
                  `ICC_ADDR_COUNT: begin
                     bresp_nxt = 2'h2;
                  end
                  default: begin
                     bresp_nxt = 2'h2;
                  end
               endcase
            end else if (s_axi_arvalid && s_axi_arready) begin
               st_nxt    = ICC_RDATA;
               rresp_nxt = 2'h0;
               case ({s_axi_araddr[3:2], 2'h0})
                  `ICC_ADDR_CONTROL: rdata_nxt = ctrl_rd;
                  `ICC_ADDR_STATUS:  rdata_nxt = {29'h0, status_r};
                  `ICC_ADDR_MASK:    rdata_nxt = {29'h0, mask_r};
                  `ICC_ADDR_COUNT:   rdata_nxt = {{(31-AW){1'b0}}, cnt_r};
                  default: begin
                     rdata_nxt = 32'h00000000;
                     rresp_nxt = 2'h2;
                  end
               endcase
            end
         end
         ICC_WRESP: begin
            if (s_axi_bready) begin
               st_nxt = ICC_IDLE;
            end
         end
         ICC_RDATA: begin
            if (s_axi_rready) begin
               st_nxt = ICC_IDLE;
            end
         end
         default: begin
            st_nxt = ICC_IDLE;
         end
      endcase
      // Set after clear so an event in the clearing cycle survives
      status_nxt = status_nxt | set_ev;
   end

   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         st_r      <= ICC_IDLE;
         rdata_r   <= 32'h00000000;
         bresp_r   <= 2'h0;
         rresp_r   <= 2'h0;
         awaddr_r  <= 4'h0;
         wdata_r   <= 32'h00000000;
         wstrb_r   <= 4'h0;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         control_r <= `ICC_CTRL_RESET;
         mask_r    <= 3'h0;
         status_r  <= 3'h0;
      end else begin
         st_r      <= st_nxt;
         rdata_r   <= rdata_nxt;
         bresp_r   <= bresp_nxt;
         rresp_r   <= rresp_nxt;
         awaddr_r  <= awaddr_nxt;
         wdata_r   <= wdata_nxt;
         wstrb_r   <= wstrb_nxt;
         aw_have_r <= aw_have_nxt;
         w_have_r  <= w_have_nxt;
         control_r <= control_nxt;
         mask_r    <= mask_nxt;
         status_r  <= status_nxt;
      end
   end

   // Disabled unit raises no interrupt even if old status stays set
   assign irq_o = enable & |(status_r & mask_r);
endmodule : icc_top

// *** testbench/icc_top_assertions.sv ***
`timescale 1ns/1ps
`include "icc_defines.svh"
module icc_top_assertions (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic        capture_pin_i,
   input wire logic        irq_o,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [3:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ------
   // Helpers
   // ------
   logic [3:0] raddr_r;
   logic [3:0] raddr_nxt;
   logic [3:0] quiet_r;
   logic [3:0] quiet_nxt;
   logic       pin_r;
   logic       pin_nxt;
   // Saturating count since the pin last moved; it bounds how late a capture may raise irq
   always_comb begin
      raddr_nxt = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : raddr_r;
      pin_nxt   = capture_pin_i;
      quiet_nxt = (capture_pin_i != pin_r) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
   end
   always_ff @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         raddr_r <= 4'h0;
         quiet_r <= 4'hf;
         pin_r   <= 1'b0;
      end else begin
         raddr_r <= raddr_nxt;
         quiet_r <= quiet_nxt;
         pin_r   <= pin_nxt;
      end
   end
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_ctrl_unimpl_zero: assert property (s_axi_rvalid && raddr_r == `ICC_ADDR_CONTROL |-> (s_axi_rdata & 32'hffff5c00) == 32'h0)
      else $error("unimplemented control bits read nonzero");
   a_irq_has_cause: assert property ($rose(irq_o) |-> quiet_r < 4'hc || s_axi_bvalid || $past(s_axi_bvalid))
      else $error("irq rose without capture or write");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped early");
   a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer changed early");
   a_busy_refuse: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_awready && !s_axi_arready)
      else $error("request accepted while answer pending");
   a_rresp_legal: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00 || s_axi_rresp == 2'b10)
      else $error("illegal read response");
endmodule : icc_top_assertions

bind icc_top icc_top_assertions u_chk (.clock_i, .reset_i, .capture_pin_i, .irq_o, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// *** testbench/icc_top_tb.sv ***
`timescale 1ns/1ps
`include "icc_defines.svh"
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("[ERR] %s exp %h got %h", n, e, a); end end
module icc_top_tb;
   localparam int DEPTH = 4;
   logic        clock_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        system_idle_i = 1'b0;
   logic        capture_pin_i = 1'b0;
   logic [31:0] second_timer_i = 32'h0;
   logic [15:0] third_timer_i = 16'h0;
   logic        buf_pop_i = 1'b0;
   logic [31:0] buf_data_o;
   logic        irq_o;
   logic [3:0]  s_axi_awaddr = 4'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready = 1'b0;
   logic [3:0]  s_axi_araddr = 4'h0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready = 1'b0;
   int          miscompares = 0;
   int          n_compared = 0;
   int          ev = 0;
   logic [31:0] q[$];
   logic [31:0] ctrl = 32'h0;
   logic [31:0] st = 32'h0;
   logic [31:0] msk = 32'h0;
   logic [31:0] rv;
   logic [1:0]  rr;
   logic        ovf = 1'b0;
   logic [31:0] tbv[3] = '{32'h180, 32'h80, 32'h0};

   icc_top #(.DEPTH(DEPTH)) dut (.clock_i, .reset_i, .system_idle_i, .capture_pin_i, .second_timer_i, .third_timer_i,
      .buf_pop_i, .buf_data_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #12.5 clock_i = ~clock_i;

   // ------
   // Bus tasks and model
   // ------
   task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clock_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      // Late bready on purpose, so the answer has to stand
      s_axi_bready <= 1'b1;
      @(posedge clock_i);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clock_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b1;
      @(posedge clock_i);
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd

   task automatic rc(input logic [3:0] a, input logic [31:0] e);
      rd(a, rv);
      `CHK("reg", e, rv)
   endtask : rc

   task automatic setc(input logic [31:0] v);
      ctrl = v & `ICC_CTRL_WMASK;
      if (!v[15]) begin
         q.delete();
         ovf = 1'b0;
         ev = 0;
      end
      wr(`ICC_ADDR_CONTROL, v, rr);
   endtask : setc

   function automatic logic [31:0] stamp();
      if (ctrl[8]) return second_timer_i;
      if (ctrl[7]) return {16'h0, second_timer_i[15:0]};
      return {16'h0, third_timer_i};
   endfunction : stamp

   function automatic logic [31:0] cexp();
      return ctrl | {27'h0, ovf, q.size() != 0, 3'h0};
   endfunction : cexp

   // Timers held steady across the edge so the stamp cycle does not matter
   task automatic tog(input bit cap);
      @(posedge clock_i);
      second_timer_i <= $urandom;
      third_timer_i <= 16'($urandom);
      capture_pin_i <= ~capture_pin_i;
      repeat (8) @(posedge clock_i);
      if (cap && q.size() == DEPTH) begin
         ovf = 1'b1;
         st[2] = 1'b1;
      end else if (cap) begin
         q.push_back(stamp());
         st[0] = 1'b1;
         ev++;
         if (ev > ctrl[6:5]) begin
            ev = 0;
            st[1] = 1'b1;
         end
      end
   endtask : tog

   task automatic popc();
      logic [31:0] e;
      @(posedge clock_i);
      e = q.pop_front();
      `CHK("data", e, buf_data_o)
      buf_pop_i <= 1'b1;
      @(posedge clock_i);
      buf_pop_i <= 1'b0;
   endtask : popc

   task automatic final_report();
      if (miscompares == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : final_report

   // ------
   // Scenarios
   // ------
   initial begin
      void'($urandom(32'h1027f5d7));
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      rc(`ICC_ADDR_CONTROL, 32'h0);
      rc(`ICC_ADDR_STATUS, 32'h0);
      setc(32'hffffffff);
      rc(`ICC_ADDR_CONTROL, 32'h0000a3e7);
      setc(32'h0);
      wr(`ICC_ADDR_COUNT, 32'h5, rr);
      `CHK("resp", 2'b10, rr)
      wr(`ICC_ADDR_MASK, 32'h2, rr);
      msk = 32'h2;
      rc(`ICC_ADDR_MASK, msk);
      foreach (tbv[i]) begin
         setc(32'h8001 | tbv[i]);
         tog(1);
         popc();
      end
      for (int c = 0; c < 4; c++) begin
         setc(32'h8001 | (c << 5));
         wr(`ICC_ADDR_STATUS, 32'h7, rr);
         st = 32'h0;
         for (int j = 0; j <= c; j++) begin
            tog(1);
            `CHK("irq", ctrl[15] && (st & msk) != 0, irq_o)
            popc();
         end
         rc(`ICC_ADDR_STATUS, st);
      end
      wr(`ICC_ADDR_MASK, 32'h0, rr);
      `CHK("irq", 1'b0, irq_o)
      wr(`ICC_ADDR_MASK, 32'h2, rr);
      setc(32'h1);
      `CHK("irq", 1'b0, irq_o)
      tog(0);
      rc(`ICC_ADDR_COUNT, 32'h0);
      wr(`ICC_ADDR_STATUS, 32'h7, rr);
      st = 32'h0;
      setc(32'h8001);
      repeat (DEPTH + 1) tog(1);
      rc(`ICC_ADDR_CONTROL, cexp());
      rc(`ICC_ADDR_COUNT, q.size());
      setc(32'h8001);
      rc(`ICC_ADDR_CONTROL, cexp());
      repeat (DEPTH) popc();
      rc(`ICC_ADDR_CONTROL, cexp());
      setc(32'h1);
      repeat (2) @(posedge clock_i);
      rc(`ICC_ADDR_CONTROL, cexp());
      for (int s = 0; s < 2; s++) begin
         setc(s ? 32'h8001 : 32'ha001);
         system_idle_i <= 1'b1;
         tog(s);
         rc(`ICC_ADDR_COUNT, q.size());
         system_idle_i <= 1'b0;
         while (q.size() != 0) popc();
      end
      for (int f = 0; f < 2; f++) begin
         setc(32'h0);
         if (capture_pin_i) tog(0);
         setc(32'h8006 | (f << 9));
         tog(f);
         if (!f) tog(1);
         rc(`ICC_ADDR_COUNT, q.size());
         while (q.size() != 0) popc();
      end
      final_report();
   end

   initial begin
      repeat (8000) @(posedge clock_i);
      miscompares++;
      final_report();
   end
endmodule : icc_top_tb
